// file: dppc_pkg.sv
`default_nettype none
package dppc_pkg;
    // number of power-enable / over-current pin pairs
    localparam int PORT_COUNT = 5;

    // reset value of the latched fault record
    localparam logic [4:0] FAULT_RESET = 5'h00;

    // all port power enables released (pin released = logic 1 level)
    localparam logic [4:0] PWR_OFF_N = 5'h1f;

    typedef struct packed {
        logic gangMode;
        logic busPoweredN;
    } dppc_mode_t;

    typedef struct packed {
        logic [4:0] drvLow;
        logic [4:0] outEn;
    } dppc_pwr_pins_t;
endpackage
`default_nettype wire

// file: dppc_power_ctrl.sv
// Behaviour
// R1 - static pin picks ganged or per-port switching
// R2 - board holds gang pin fixed during operation
// R3 - over-current inputs active low, one per port
// R4 - ganged: over-current inputs combined into one
// R5 - unused over-current inputs tied high
// R6 - active-low open-drain power enable per port
// R7 - ganged: all enables switch together, same state
// R8 - reset held low at least 250 ns
// R9 - reset held no longer than 5 ms
// R10 - enables derived from gang, bus-power, over-current; the code uses gang and over-current, bus-power gates nothing
// R11 - ganged: board ties over-current inputs together
// R12 - over-current releases enable, records event
`timescale 1ns/1ns
`default_nettype none
module dppc_power_ctrl #(
    parameter int PORTS = dppc_pkg::PORT_COUNT
)
(
    input  wire logic                     ref_clk,
    input  wire logic                     reset_n,
    input  wire logic                     gangMode,
    input  wire logic                     bus_powered_select_n,
    input  wire logic [PORTS-1:0]         overcurrent_flag_n,
    input  wire logic [PORTS-1:0]         portPowerRequest,
    input  wire logic [PORTS-1:0]         faultClear,
    output var  logic [PORTS-1:0]         port_power_enable_n_out,
    output var  logic [PORTS-1:0]         port_power_enable_n_oe,
    output var  logic [PORTS-1:0]         faultSeen,
    output var  logic [PORTS-1:0]         faultEvent
);
    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    logic [PORTS-1:0]     ocSyncN;
    logic [1:0]           modeSync;
    dppc_pkg::dppc_mode_t mode;

    dppc_sync #(
        .WIDTH     (PORTS),
        .RESET_VAL (32'hffff_ffff)
    ) u_oc_sync (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .asyncIn (overcurrent_flag_n),
        .syncOut (ocSyncN)
    );

    dppc_sync #(
        .WIDTH     (2),
        .RESET_VAL (32'h0000_0001)
    ) u_mode_sync (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .asyncIn ({gangMode, bus_powered_select_n}),
        .syncOut (modeSync)
    );

    // mode pins are static, so sampling them like data is enough
    assign mode = dppc_pkg::dppc_mode_t'(modeSync); // R1

    // copy one value onto every port, as ganged switching needs
    function automatic logic [PORTS-1:0] spread(input logic b);
        spread = {PORTS{b}};
    endfunction

    // ----------------------------------------------------------------
    // over-current decode
    // ----------------------------------------------------------------
    logic [PORTS-1:0] ocActive;
    logic             ocCommon;

    // low level means over-current; tied-high inputs never fire
    assign ocCommon = |(~ocSyncN); // R4

    always_comb
    begin
        if (mode.gangMode)
            ocActive = spread(ocCommon); // R4
        else
            ocActive = ~ocSyncN; // R3
    end

    // ----------------------------------------------------------------
    // fault record
    // ----------------------------------------------------------------
    logic [PORTS-1:0] fault_r;
    logic [PORTS-1:0] fault_nxt;
    logic [PORTS-1:0] event_r;
    logic [PORTS-1:0] event_nxt;
    logic [PORTS-1:0] ocPrev_r;
    logic [PORTS-1:0] ocPrev_nxt;

    always_comb
    begin
        // set wins over clear: a port still in over-current cannot be
        // re-armed by software until its pin goes high again
        fault_nxt  = (fault_r & ~faultClear) | ocActive; // R12
        event_nxt  = ocActive & ~ocPrev_r; // R12
        ocPrev_nxt = ocActive;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fault_r  <= dppc_pkg::FAULT_RESET;
            event_r  <= '0;
            ocPrev_r <= '0;
        end
        else
        begin
            fault_r  <= fault_nxt;
            event_r  <= event_nxt;
            ocPrev_r <= ocPrev_nxt;
        end
    end

    // ----------------------------------------------------------------
    // power enable
    // ----------------------------------------------------------------
    logic [PORTS-1:0] pwrOn_r;
    logic [PORTS-1:0] pwrOn_nxt;
    logic [PORTS-1:0] drainLow_r;
    logic [PORTS-1:0] drainLow_nxt;
    logic             gangReq;

    // in ganged mode port 0's request steers every port
    assign gangReq = portPowerRequest[0];

    always_comb
    begin
        // the pin only ever pulls low; release comes from the enable
        drainLow_nxt = '0; // R6
        if (mode.gangMode)
            pwrOn_nxt = spread(gangReq & ~ocCommon & ~fault_r[0]); // R7
        else
            pwrOn_nxt = portPowerRequest & ~ocActive & ~fault_r; // R10
        // limitation: the bus-power pin is sampled but gates no switching
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pwrOn_r    <= '0;
            drainLow_r <= '0;
        end
        else
        begin
            pwrOn_r    <= pwrOn_nxt;
            drainLow_r <= drainLow_nxt;
        end
    end

    // ----------------------------------------------------------------
    // open-drain pins: level held low, enable set while powered
    // ----------------------------------------------------------------
    dppc_pkg::dppc_pwr_pins_t pins;

    assign pins = '{drvLow: drainLow_r, outEn: pwrOn_r};
    assign port_power_enable_n_out = pins.drvLow; // R6
    assign port_power_enable_n_oe  = pins.outEn; // R6
    assign faultSeen               = fault_r;
    assign faultEvent              = event_r;

    // ----------------------------------------------------------------
    // mode settle count
    // ----------------------------------------------------------------
    // the mode synchroniser shows the pins two edges after reset; the
    // static-mode check waits until this count is full
    logic [1:0] settle_r;
    logic [1:0] settle_nxt;

    always_comb
    begin
        settle_nxt = settle_r;
        if (settle_r != 2'h3)
            settle_nxt = settle_r + 2'h1;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            settle_r <= 2'h0;
        else
            settle_r <= settle_nxt;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_gang_same_state: assert property // R7
        (@(posedge ref_clk) disable iff (!reset_n)
        mode.gangMode |=> (pwrOn_r == {PORTS{pwrOn_r[0]}}) || $changed(mode))
        else $error("ganged enables differ");
    a_oc_releases: assert property // R12
        (@(posedge ref_clk) disable iff (!reset_n)
        (|ocActive) |=> ((pwrOn_r & $past(ocActive)) == '0))
        else $error("enable held during over-current");
    a_oc_recorded: assert property // R12
        (@(posedge ref_clk) disable iff (!reset_n)
        (|ocActive) |=> ((fault_r & $past(ocActive)) == $past(ocActive)))
        else $error("over-current not recorded");
    a_drain_only: assert property // R6
        (@(posedge ref_clk) disable iff (!reset_n)
        port_power_enable_n_out == '0)
        else $error("enable pin driven high");
    a_perport_indep: assert property // R3 R10
        (@(posedge ref_clk) disable iff (!reset_n)
        (!mode.gangMode && !ocActive[1] && !fault_r[1] && portPowerRequest[1]
            && !$changed(mode)) |=> pwrOn_r[1])
        else $error("port not powered on request");
    a_gang_common_oc: assert property // R4
        (@(posedge ref_clk) disable iff (!reset_n)
        (mode.gangMode && !ocSyncN[PORTS-1]) |-> ocActive[0])
        else $error("ganged over-current not shared");
    a_event_pulse: assert property // R12
        (@(posedge ref_clk) disable iff (!reset_n)
        faultEvent[0] |=> !faultEvent[0])
        else $error("fault event longer than a cycle");
    a_fault_sticky: assert property // R12
        (@(posedge ref_clk) disable iff (!reset_n)
        (fault_r[0] && !faultClear[0]) |=> fault_r[0])
        else $error("fault record lost");
    a_mode_static: assert property // R1
        (@(posedge ref_clk) disable iff (!reset_n)
        (settle_r == 2'h3) |-> $stable(mode))
        else $error("mode pins moved during operation");
    a_fault_blocks: assert property // R12
        (@(posedge ref_clk) disable iff (!reset_n)
        (!mode.gangMode && fault_r[2]) |=> !pwrOn_r[2])
        else $error("power held while fault recorded");
    a_gang_power_on: assert property // R7 R10
        (@(posedge ref_clk) disable iff (!reset_n)
        (mode.gangMode && portPowerRequest[0] && !ocCommon && !fault_r[0])
            |=> (pwrOn_r == {PORTS{1'b1}}))
        else $error("ganged ports not powered on request");
    a_no_power_idle: assert property // R10
        (@(posedge ref_clk) disable iff (!reset_n)
        (!mode.gangMode && portPowerRequest == '0) |=> (pwrOn_r == '0))
        else $error("port powered without request");
endmodule // dppc_power_ctrl
`default_nettype wire

// file: dppc_power_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin nCompared++; if ((got) !== (ex)) begin \
 numErrors++; $display("Error %s exp %h got %h", nm, ex, got); end end
module dppc_power_ctrl_test;
    logic       ref_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       gangMode = 1'b0;
    logic       busPwrN = 1'b1;
    logic [4:0] req = 5'h00;
    logic [4:0] clr = 5'h00;
    logic [4:0] inject = 5'h00;
    logic [4:0] pOut, pOe, fSeen, fEvt, level, flagN;
    int         numErrors = 0;
    int         nCompared = 0;

    dppc_power_ctrl i_dppc_power_ctrl (.ref_clk(ref_clk),
        .reset_n(reset_n), .gangMode(gangMode),
        .bus_powered_select_n(busPwrN), .overcurrent_flag_n(flagN),
        .portPowerRequest(req), .faultClear(clr),
        .port_power_enable_n_out(pOut), .port_power_enable_n_oe(pOe),
        .faultSeen(fSeen), .faultEvent(fEvt));
    dppc_switch_model i_dppc_switch_model (.gangMode(gangMode),
        .pinOe(pOe), .pinOut(pOut), .faultInject(inject),
        .pinLevel(level), .flagN(flagN));

    initial forever #20 ref_clk = ~ref_clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // mode pins only change under reset; 7 cycles keep reset over 250 ns
    task automatic startUp(input logic g, input logic b);
        reset_n = 1'b0;
        gangMode = g;
        busPwrN = b;
        req = 5'h00;
        cyc(7);
        `CHK("oe in reset", 5'h00, pOe)
        `CHK("fault in reset", 5'h00, fSeen)
        `CHK("event in reset", 5'h00, fEvt)
        `CHK("level in reset", dppc_pkg::PWR_OFF_N, level)
        reset_n = 1'b1;
        cyc(3);
    endtask

    task automatic perPort();
        startUp(1'b0, 1'b1);
        for (int i = 0; i < 5; i++)
        begin
            req[i] = 1'b1;
            cyc(1);
            `CHK("oe step", (5'h01 << (i + 1)) - 5'h01, pOe)
        end
        `CHK("pin level", 5'h00, level)
        `CHK("pin drive", 5'h00, pOut)
        inject[2] = 1'b1;
        cyc(3);
        `CHK("oe fault", 5'h1b, pOe)
        `CHK("fault seen", 5'h04, fSeen)
        `CHK("fault pulse", 5'h04, fEvt)
        `CHK("pin released", 5'h04, level)
        clr[2] = 1'b1;
        cyc(1);
        clr[2] = 1'b0;
        `CHK("pulse end", 5'h00, fEvt)
        `CHK("set wins", 5'h04, fSeen)
        inject[2] = 1'b0;
        cyc(3);
        `CHK("fault held", 5'h1b, pOe)
        clr[2] = 1'b1;
        cyc(1);
        clr[2] = 1'b0;
        cyc(2);
        `CHK("re-enabled", 5'h1f, pOe)
        `CHK("fault cleared", 5'h00, fSeen)
    endtask

    task automatic ganged();
        startUp(1'b1, 1'b0);
        req = 5'h1e;
        cyc(2);
        `CHK("gang ignores", 5'h00, pOe)
        req = 5'h01;
        cyc(1);
        `CHK("gang on", 5'h1f, pOe)
        `CHK("gang level", 5'h00, level)
        inject[4] = 1'b1;
        cyc(3);
        `CHK("gang fault", 5'h00, pOe)
        `CHK("gang seen", 5'h1f, fSeen)
        `CHK("gang event", 5'h1f, fEvt)
        inject[4] = 1'b0;
        cyc(3);
        clr = 5'h1f;
        cyc(1);
        clr = 5'h00;
        cyc(2);
        `CHK("gang back", 5'h1f, pOe)
    endtask

    task automatic testDone();
        if (numErrors == 0 && nCompared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        perPort();
        ganged();
        testDone();
    end

    // both scenarios take under 100 cycles
    initial
    begin
        #100000;
        numErrors++;
        testDone();
    end
endmodule // dppc_power_ctrl_test
`default_nettype wire

// file: dppc_switch_model.sv
`timescale 1ns/1ns
`default_nettype none
module dppc_switch_model
(
    input  wire logic       gangMode,
    input  wire logic [4:0] pinOe,
    input  wire logic [4:0] pinOut,
    input  wire logic [4:0] faultInject,
    output var  logic [4:0] pinLevel,
    output var  logic [4:0] flagN
);
    always_comb
    begin
        // pull-up on each open-drain line: a released pin reads high
        for (int i = 0; i < 5; i++)
            pinLevel[i] = pinOe[i] ? pinOut[i] : 1'b1;
        // ganged board shares one fault line across all inputs
        if (gangMode)
            flagN = {5{~|faultInject}};
        else
            flagN = ~faultInject;
    end
endmodule // dppc_switch_model
`default_nettype wire

// file: dppc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module dppc_sync #(
    parameter int          WIDTH     = 1,
    parameter logic [31:0] RESET_VAL = 32'h0000_0000
)
(
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output var  logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1_r <= RESET_VAL[WIDTH-1:0];
            stage2_r <= RESET_VAL[WIDTH-1:0];
        end
        else
        begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
        end
    end

    assign syncOut = stage2_r;
endmodule // dppc_sync
`default_nettype wire
